// file: src/dll_seq_map.svh
// constants for the power-up and dll lock sequencer
`ifndef DLL_SEQ_MAP_SVH
`define DLL_SEQ_MAP_SVH
`define REF_CLK_PERIOD_PS      5000
`define CLK_STOP_TIME_PS       30000
`define CLK_STOP_CYCLES        ((`CLK_STOP_TIME_PS + `REF_CLK_PERIOD_PS - 1) / `REF_CLK_PERIOD_PS)
`define DLL_LOCK_PERIOD_CYCLES 2048
`define LOCK_COUNT_WIDTH       12
`define STOP_COUNT_WIDTH       8
`endif

// file: src/dll_seq_pkg.sv
// types shared by the power-up and dll lock sequencer
`default_nettype none
package dll_seq_pkg;
	typedef enum logic [1:0] {
		SEQ_WAIT_CLOCK,
		SEQ_LOCKING,
		SEQ_READY
	} seq_state_type;

	typedef struct packed {
		logic ready;       // normal operation allowed
		logic dll_locked;  // dll holds lock
		logic dll_bypass;  // legacy one-cycle latency mode
	} seq_status_type;
endpackage
`default_nettype wire

// file: src/sram_dll_powerup_init.sv
// power-up initialisation and dll lock/reset sequencer of a burst sram
// Notes on behaviour
// (R1) ready only after the lock period of stable input clock cycles
// (R2) lock period initialises logic and locks dll when enabled
// (R3) disable pin low: skip dll lock, only initialise
// (R4) disable pin low from power-on: ready after the lock period
// (R5) controller holds all inputs at defined levels during power-on
// (R6) controller raises disable pin only once the clock is stable
// (R7) early disable-pin rise needs dll reset and relock by controller
// (R8) clock static over 30 ns resets dll, relock, then ready
// (R9) disable pin rising edge resets dll, relock, then ready
// (R10) frequency change needs a dll reset by the controller
// (R11) dll locks after 2048 stable input clock cycles
// (R12) bypassed dll gives one-cycle read latency, legacy mode
// (R13) controller waits the full lock period before commands
`timescale 1ns/100ps
`default_nettype none
`include "dll_seq_map.svh"
module sram_dll_powerup_init
	import dll_seq_pkg::*;
(
	input  wire logic     ref_clk,      // 200 MHz sampling clock
	input  wire logic     rstn,         // async reset, active low
	input  wire logic     k_clk,        // input clock, true phase
	input  wire logic     k_clk_n,      // input clock, inverted phase
	input  wire logic     dll_enable,   // dll disable pin, low = bypass
	output var  logic     ready,        // device ready for operation
	output var  logic     dll_locked,   // dll holds lock
	output var  logic     dll_bypass,   // legacy one-cycle latency mode
	output var  logic     read_latency  // 0: dll latency, 1: one cycle
);
	// two-flop synchronisers; first stage read only by second
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic       k_prev;
	logic       kn_prev;
	logic       en_prev;
	// history is trusted only once both sync stages and prev are loaded
	logic [2:0] primed;

	logic                           k_s;
	logic                           kn_s;
	logic                           en_s;
	logic                           k_edge;
	logic                           kn_edge;
	logic                           en_rise;
	logic                           stopped;

	seq_state_type                  state;
	seq_state_type                  next_state;
	logic [`LOCK_COUNT_WIDTH-1:0]   lock_count;
	logic [`LOCK_COUNT_WIDTH-1:0]   next_lock_count;
	logic [`STOP_COUNT_WIDTH-1:0]   stop_count;
	logic [`STOP_COUNT_WIDTH-1:0]   next_stop_count;
	logic                           lock_done;
	seq_status_type                 status;
	seq_status_type                 next_status;
	logic                           next_read_latency;

	localparam logic [`STOP_COUNT_WIDTH-1:0] STOP_LIMIT =
		`STOP_COUNT_WIDTH'(`CLK_STOP_CYCLES);
	localparam logic [`LOCK_COUNT_WIDTH-1:0] LOCK_LAST =
		`LOCK_COUNT_WIDTH'(`DLL_LOCK_PERIOD_CYCLES - 1);

	// pin sampling and edge history
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_a  <= 3'h0;
			sync_b  <= 3'h0;
			k_prev  <= 1'b0;
			kn_prev <= 1'b0;
			en_prev <= 1'b0;
			primed  <= 3'h0;
		end
		else
		begin
			sync_a  <= {dll_enable, k_clk_n, k_clk};
			sync_b  <= sync_a;
			k_prev  <= sync_b[0];
			kn_prev <= sync_b[1];
			en_prev <= sync_b[2];
			primed  <= {primed[1:0], 1'b1};
		end
	end

	assign k_s     = sync_b[0];
	assign kn_s    = sync_b[1];
	assign en_s    = sync_b[2];
	assign k_edge  = primed[2] && (k_s != k_prev);
	assign kn_edge = primed[2] && (kn_s != kn_prev);
	// primed keeps a pin already high at reset from faking a toggle
	assign en_rise = primed[2] && en_s && !en_prev; // R9
	// either phase standing still too long counts as a stop
	assign stopped = (stop_count >= STOP_LIMIT); // R8
	assign lock_done = (lock_count == LOCK_LAST);

	// next values of the sequencer
	always_comb
	begin
		next_state        = state;
		next_lock_count   = lock_count;
		next_stop_count   = stop_count;
		next_status       = status;
		next_read_latency = read_latency;
		if (k_edge && kn_edge)
			next_stop_count = '0;
		else if (!stopped)
			next_stop_count = stop_count + 1'b1;
		// bypass follows the pin level, dll unused while low
		next_status.dll_bypass = !en_s; // R3 R12
		next_read_latency      = !en_s; // R12
		case (state)
			SEQ_WAIT_CLOCK:
			begin
				next_lock_count    = '0;
				next_status.ready  = 1'b0;
				next_status.dll_locked = 1'b0;
				if (!stopped)
					next_state = SEQ_LOCKING;
			end
			SEQ_LOCKING:
			begin
				// one count per rising edge of the true phase
				if (k_edge && k_s)
					next_lock_count = lock_count + 1'b1; // R11
				if (stopped || en_rise)
					next_state = SEQ_WAIT_CLOCK; // R8 R9
				else if (k_edge && k_s && lock_done)
				begin
					next_state             = SEQ_READY; // R1 R4
					next_status.ready      = 1'b1;
					next_status.dll_locked = en_s; // R2 R3
				end
			end
			SEQ_READY:
			begin
				if (stopped || en_rise)
				begin
					next_state             = SEQ_WAIT_CLOCK; // R8 R9
					next_status.ready      = 1'b0;
					next_status.dll_locked = 1'b0;
				end
				else
					next_status.dll_locked = en_s;
			end
			default:
				next_state = SEQ_WAIT_CLOCK;
		endcase
	end

	// sequencer registers; counts start from a stopped clock
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state        <= SEQ_WAIT_CLOCK;
			lock_count   <= '0;
			stop_count   <= STOP_LIMIT;
			status       <= '0;
			read_latency <= 1'b0;
		end
		else
		begin
			state        <= next_state;
			lock_count   <= next_lock_count;
			stop_count   <= next_stop_count;
			status       <= next_status;
			read_latency <= next_read_latency;
		end
	end

	// ready, dll_locked and dll_bypass are the registered status fields
	assign ready      = status.ready;
	assign dll_locked = status.dll_locked;
	assign dll_bypass = status.dll_bypass;

	// checks
	ready_after_lock_a: assert property ( // R1
		@(posedge ref_clk) disable iff (!rstn)
		$rose(ready) |-> $past(state) == SEQ_LOCKING && $past(lock_done))
		else $error("ready rose without a full lock period");
	stop_resets_a: assert property ( // R8
		@(posedge ref_clk) disable iff (!rstn)
		stopped |=> !ready)
		else $error("ready held through a clock stop");
	rise_resets_a: assert property ( // R9
		@(posedge ref_clk) disable iff (!rstn)
		en_rise && state != SEQ_WAIT_CLOCK |=> !ready && !dll_locked)
		else $error("disable pin toggle did not reset the dll");
	bypass_no_lock_a: assert property ( // R3
		@(posedge ref_clk) disable iff (!rstn)
		dll_bypass |-> !dll_locked)
		else $error("dll locked while bypassed");
	lock_count_step_a: assert property ( // R11
		@(posedge ref_clk) disable iff (!rstn)
		state == SEQ_LOCKING && $past(state) == SEQ_LOCKING
		&& !$past(k_edge && k_s) |-> $stable(lock_count))
		else $error("lock count moved without a clock edge");
	locked_needs_ready_a: assert property ( // R2
		@(posedge ref_clk) disable iff (!rstn)
		dll_locked |-> ready)
		else $error("dll locked outside ready");
	latency_mode_a: assert property ( // R12
		@(posedge ref_clk) disable iff (!rstn)
		read_latency == dll_bypass)
		else $error("read latency mode does not follow bypass");
	wait_not_ready_a: assert property ( // R4
		@(posedge ref_clk) disable iff (!rstn)
		state == SEQ_WAIT_CLOCK ##1 state == SEQ_LOCKING |-> !ready)
		else $error("ready during lock period");
	ready_holds_a: assert property ( // R1
		@(posedge ref_clk) disable iff (!rstn)
		ready && !stopped && !en_rise |=> ready)
		else $error("ready dropped without a dll reset");
	ready_cover: cover property (@(posedge ref_clk) disable iff (!rstn)
		$rose(ready));
	bypass_cover: cover property (@(posedge ref_clk) disable iff (!rstn)
		ready && dll_bypass);
	stop_cover: cover property (@(posedge ref_clk) disable iff (!rstn)
		ready ##1 stopped);
	toggle_cover: cover property (@(posedge ref_clk) disable iff (!rstn)
		ready && en_rise);
endmodule
`default_nettype wire

// file: testbench/k_clock_model.sv
// controller model: drives the input clock pair of the sequencer
`timescale 1ns/100ps
`default_nettype none
module k_clock_model
(
	input  wire logic run,     // pair toggles while high
	output var  logic k_clk,   // true phase
	output var  logic k_clk_n  // inverted phase
);
	// stopped pair stays at a valid level, never left floating
	initial k_clk = 1'b0;
	// 48 ns period; a stop is also how the controller resets the dll
	always #24 if (run) k_clk = ~k_clk;
	assign k_clk_n = ~k_clk;
endmodule
`default_nettype wire

// file: testbench/tb_sram_dll_powerup_init.sv
// testbench of the power-up and dll lock sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_sram_dll_powerup_init;
	logic ref_clk, rstn, run, dll_enable;
	logic ready, dll_locked, dll_bypass, read_latency;
	wire logic k_clk, k_clk_n;
	int n_errors, n_compared;
	k_clock_model partner (.run(run), .k_clk(k_clk), .k_clk_n(k_clk_n));
	sram_dll_powerup_init dut (.ref_clk(ref_clk), .rstn(rstn),
		.k_clk(k_clk), .k_clk_n(k_clk_n), .dll_enable(dll_enable),
		.ready(ready), .dll_locked(dll_locked), .dll_bypass(dll_bypass),
		.read_latency(read_latency));
	// 200 MHz sampling clock
	initial ref_clk = 1'b0;
	always #2.5 ref_clk = ~ref_clk;
	task automatic compare_bit(input string what, input logic exp,
		input logic seen);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ready must stay low until the full count, then rise promptly
	task automatic lock_check(input logic dll_on);
		repeat (2040) @(posedge k_clk);
		@(negedge ref_clk);
		compare_bit("ready early", 1'b0, ready);
		repeat (20) @(posedge k_clk);
		@(negedge ref_clk);
		compare_bit("ready", 1'b1, ready);
		compare_bit("dll_locked", dll_on, dll_locked);
		compare_bit("dll_bypass", ~dll_on, dll_bypass);
		compare_bit("read_latency", ~dll_on, read_latency);
	endtask
	// disable pin low from power-on: only initialisation is done
	task automatic powerup_bypass;
		repeat (4) @(negedge ref_clk);
		rstn = 1'b1;
		run = 1'b1;
		lock_check(1'b0);
	endtask
	// pin raised on a stable clock resets the dll and relocks
	task automatic enable_toggle;
		@(negedge ref_clk);
		dll_enable = 1'b1;
		repeat (8) @(negedge ref_clk);
		compare_bit("ready after pin rise", 1'b0, ready);
		lock_check(1'b1);
	endtask
	// clock held static for 80 ns resets the dll
	task automatic clock_stop;
		@(negedge ref_clk);
		run = 1'b0;
		repeat (16) @(negedge ref_clk);
		compare_bit("ready after stop", 1'b0, ready);
		run = 1'b1;
		lock_check(1'b1);
	endtask
	// pin dropped while ready: dll bypassed, device stays ready
	task automatic enable_drop;
		@(negedge ref_clk);
		dll_enable = 1'b0;
		repeat (8) @(negedge ref_clk);
		compare_bit("ready in bypass", 1'b1, ready);
		compare_bit("dll_locked in bypass", 1'b0, dll_locked);
		compare_bit("dll_bypass after drop", 1'b1, dll_bypass);
		compare_bit("read_latency after drop", 1'b1, read_latency);
	endtask
	// main sequence; inputs all defined from time zero
	initial
	begin
		rstn = 1'b0;
		run = 1'b0;
		dll_enable = 1'b0;
		n_errors = 0;
		n_compared = 0;
		powerup_bypass();
		enable_toggle();
		clock_stop();
		enable_drop();
		complete_run();
	end
	// three lock periods take about 300 us
	initial
	begin
		#400000;
		n_errors++;
		complete_run();
	end
endmodule
`default_nettype wire
